// [core/ddsc_link.sv]
// Purpose: serial-clock side of the command port: shift, hold, serial out
// Assumes: serial clock may stop outside frames; frame select frames it
// Notes:   readback word and mode levels are quasi-static during a frame
`include "ddsc_map.svh"
module ddsc_link
    import ddsc_pkg::*;
(
    input wire logic i_sclk,
    input wire logic i_frame_select_n,
    input wire logic i_serial_data_in,
    input wire logic i_chain_enable,
    input wire logic i_readback_enable,
    input wire ddsc_frame_t i_readback_word,
    output ddsc_frame_t o_frame_word,
    output logic o_serial_data_out
);

    ddsc_frame_t shift_reg;
    logic [`DDSC_BIT_COUNT_W-1:0] fall_count;
    logic [`DDSC_BIT_COUNT_W-1:0] out_index;
    logic chain_bit;

    // ----------------------------------------------------------------
    // input shifting
    // ----------------------------------------------------------------
    // sample on falling edges inside the frame only
    always_ff @(negedge i_sclk) begin
        if (!i_frame_select_n) begin
            shift_reg <= {shift_reg[`DDSC_FRAME_BITS-2:0],
                i_serial_data_in};
        end
    end

    // counter held at zero between frames, so every frame starts clean
    always_ff @(negedge i_sclk or posedge i_frame_select_n) begin
        if (i_frame_select_n) begin
            fall_count <= '0;
        end else if (fall_count != `DDSC_BIT_COUNT_MAX) begin
            fall_count <= fall_count + 5'h01;
        end
    end

    // word captured by the frame's own end; short frames count too
    always_ff @(posedge i_frame_select_n) begin
        o_frame_word <= shift_reg;
    end

    // ----------------------------------------------------------------
    // serial output
    // ----------------------------------------------------------------
    // change on rising edges, so the bit is stable at the next fall
    always_ff @(posedge i_sclk or posedge i_frame_select_n) begin
        if (i_frame_select_n) begin
            out_index <= '0;
            chain_bit <= 1'b0;
        end else begin
            out_index <= fall_count;
            chain_bit <= shift_reg[`DDSC_FRAME_BITS-1];
        end
    end

    wire rb_in_range = (out_index <= `DDSC_LAST_INDEX);
    wire [`DDSC_BIT_COUNT_W-1:0] rb_pos = `DDSC_LAST_INDEX - out_index;
    wire rb_bit = rb_in_range & i_readback_word[rb_pos];

    // readback overrides the chain output, enabled or not, for one frame
    assign o_serial_data_out = i_readback_enable ? rb_bit :
        (i_chain_enable ? chain_bit : 1'b0);

endmodule

// [core/ddsc_map.svh]
// Purpose: offsets, field positions, codes and reset values for the
//          dual dac serial command port
// Assumes: included by bare name from the package and the design files
// Notes:   definitions only
`ifndef DDSC_MAP_SVH
`define DDSC_MAP_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define DDSC_FRAME_BITS 24
`define DDSC_CMD_HI 23
`define DDSC_CMD_LO 20
`define DDSC_ADDR_B_BIT 19
`define DDSC_ADDR_A_BIT 16
`define DDSC_CODE_HI 15
`define DDSC_CODE_LO 6
`define DDSC_PMODE_B_HI 7
`define DDSC_PMODE_B_LO 6
`define DDSC_PMODE_A_HI 1
`define DDSC_PMODE_A_LO 0
`define DDSC_MASK_A_BIT 0
`define DDSC_MASK_B_BIT 1
`define DDSC_FLAG_BIT 0

// ----------------------------------------------------------------
// reset values and bit counter limits
// ----------------------------------------------------------------
`define DDSC_RESET_CODE 10'h000
`define DDSC_RESET_PMODE 2'h0
`define DDSC_RESET_MASK 2'h0
`define DDSC_RESET_REF 1'b1
`define DDSC_RESET_CHAIN 1'b0
`define DDSC_BIT_COUNT_W 5
`define DDSC_BIT_COUNT_MAX 5'h1F
`define DDSC_LAST_INDEX 5'h17

`endif

// [core/ddsc_pkg.sv]
// Purpose: shared types of the dual dac serial command port
// Assumes: ddsc_map.svh holds the numbers
// Notes:   command encodings are the frame's four top bits
`include "ddsc_map.svh"

package ddsc_pkg;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef logic [9:0] ddsc_code_t;
    typedef logic [1:0] ddsc_pmode_t;
    typedef logic [`DDSC_FRAME_BITS-1:0] ddsc_frame_t;

    typedef enum logic [3:0] {
        DDSC_CMD_NOP = 4'h0,
        DDSC_CMD_WRITE_INPUT = 4'h1,
        DDSC_CMD_UPDATE = 4'h2,
        DDSC_CMD_WRITE_UPDATE = 4'h3,
        DDSC_CMD_POWER = 4'h4,
        DDSC_CMD_LOAD_MASK = 4'h5,
        DDSC_CMD_SOFT_RESET = 4'h6,
        DDSC_CMD_REF_SETUP = 4'h7,
        DDSC_CMD_CHAIN = 4'h8,
        DDSC_CMD_READBACK = 4'h9
    } ddsc_cmd_t;

endpackage

// [core/ddsc_sync.sv]
// Purpose: three-flop synchroniser for a pin level
// Assumes: input is asynchronous to i_clock
// Notes:   the output moves only when the second and third stage agree
module ddsc_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // stage1 feeds stage2 only, so metastability never reaches logic
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            o_level <= RESET_LEVEL;
        end else begin
            stage1 <= i_pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                o_level <= stage3;
            end
        end
    end

endmodule

// [core/ddsc_top.sv]
// Purpose: command decoder and channel registers of a dual 10-bit dac
// Assumes: i_clock 100 MHz; serial clock and pins asynchronous to it
// Notes:   analog parts are outside; outputs carry codes and modes only
`include "ddsc_map.svh"

module ddsc_top
    import ddsc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_sclk,
    input wire logic i_frame_select_n,
    input wire logic i_serial_data_in,
    input wire logic i_load_dac_n,
    input wire logic i_gain_select,
    output logic o_serial_data_out,
    output ddsc_code_t o_dac_code_a,
    output ddsc_code_t o_dac_code_b,
    output ddsc_code_t o_input_code_a,
    output ddsc_code_t o_input_code_b,
    output ddsc_pmode_t o_power_mode_a,
    output ddsc_pmode_t o_power_mode_b,
    output logic [1:0] o_load_mask,
    output logic o_ref_enable,
    output logic o_chain_enable_flag,
    output logic o_gain_two,
    output logic o_frame_done
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ddsc_frame_t frame_word;
    ddsc_frame_t held_word;
    logic fs_level;
    logic fs_prev;
    logic ld_level;
    logic ld_prev;
    logic gain_level;
    logic readback_pending;
    logic readback_sel_b;
    ddsc_frame_t readback_word;
    ddsc_code_t input_reg [2];
    ddsc_code_t dac_reg [2];
    ddsc_pmode_t power_mode [2];
    logic [1:0] load_mask;
    logic ref_enable;
    logic chain_enable;

    // ----------------------------------------------------------------
    // link side
    // ----------------------------------------------------------------
    // readback enable and word only change after a frame has ended
    ddsc_link u_link (
        .i_sclk(i_sclk),
        .i_frame_select_n(i_frame_select_n),
        .i_serial_data_in(i_serial_data_in),
        .i_chain_enable(chain_enable),
        .i_readback_enable(readback_pending),
        .i_readback_word(readback_word),
        .o_frame_word(frame_word),
        .o_serial_data_out(o_serial_data_out)
    );

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    ddsc_sync #(.RESET_LEVEL(1'b1)) u_sync_fs (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(i_frame_select_n),
        .o_level(fs_level)
    );

    ddsc_sync #(.RESET_LEVEL(1'b1)) u_sync_ld (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(i_load_dac_n),
        .o_level(ld_level)
    );

    ddsc_sync #(.RESET_LEVEL(1'b0)) u_sync_gain (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(i_gain_select),
        .o_level(gain_level)
    );

    // edge history of the synchronised levels
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            fs_prev <= 1'b1;
            ld_prev <= 1'b1;
        end else begin
            fs_prev <= fs_level;
            ld_prev <= ld_level;
        end
    end

    // ----------------------------------------------------------------
    // events
    // ----------------------------------------------------------------
    // the held word is read only after the synchronised rise, by which
    // time it has been stable for several system clocks
    wire frame_end = fs_level & ~fs_prev;
    wire ld_fall = ~ld_level & ld_prev;
    wire ld_low = ~ld_level;
    // a strobe edge inside a frame is not an update
    wire ld_update = ld_fall & fs_level;

    // ----------------------------------------------------------------
    // frame field decode
    // ----------------------------------------------------------------
    assign held_word = frame_word;
    wire [3:0] command_field = held_word[`DDSC_CMD_HI:`DDSC_CMD_LO];
    wire sel_b = held_word[`DDSC_ADDR_B_BIT];
    wire sel_a = held_word[`DDSC_ADDR_A_BIT];
    wire [1:0] chan_sel = {sel_b, sel_a};
    // straight binary, no offset or sign handling needed
    wire ddsc_code_t frame_code =
        held_word[`DDSC_CODE_HI:`DDSC_CODE_LO];
    wire ddsc_pmode_t pmode_b =
        held_word[`DDSC_PMODE_B_HI:`DDSC_PMODE_B_LO];
    wire ddsc_pmode_t pmode_a =
        held_word[`DDSC_PMODE_A_HI:`DDSC_PMODE_A_LO];
    wire frame_flag = held_word[`DDSC_FLAG_BIT];
    wire [1:0] frame_mask = {held_word[`DDSC_MASK_B_BIT],
        held_word[`DDSC_MASK_A_BIT]};

    // ----------------------------------------------------------------
    // command strobes
    // ----------------------------------------------------------------
    // codes above readback fall through every compare: no operation
    wire do_write = frame_end &
        (command_field == DDSC_CMD_WRITE_INPUT);
    wire do_update = frame_end &
        (command_field == DDSC_CMD_UPDATE);
    wire do_write_upd = frame_end &
        (command_field == DDSC_CMD_WRITE_UPDATE);
    wire do_power = frame_end &
        (command_field == DDSC_CMD_POWER);
    wire do_mask = frame_end &
        (command_field == DDSC_CMD_LOAD_MASK);
    wire do_soft_rst = frame_end &
        (command_field == DDSC_CMD_SOFT_RESET);
    wire do_ref = frame_end &
        (command_field == DDSC_CMD_REF_SETUP);
    wire do_chain = frame_end &
        (command_field == DDSC_CMD_CHAIN);
    wire do_readback = frame_end &
        (command_field == DDSC_CMD_READBACK);
    // reserved codes assert none of the strobes above
    wire is_reserved = command_field > DDSC_CMD_READBACK;
    wire do_any = frame_end & ~is_reserved;

    // readback picks b only when b alone is addressed, else a
    wire rb_pick_b = sel_b & ~sel_a;

    // ----------------------------------------------------------------
    // per-channel input and dac registers
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            wire addressed = chan_sel[ch];
            wire transparent = ld_low & ~load_mask[ch];
            wire wr_in = (do_write | do_write_upd) & addressed;
            wire dac_from_frame = addressed &
                (do_write_upd | (do_write & transparent));
            wire dac_from_input = (do_update & addressed) |
                (ld_update & ~load_mask[ch]);

            // input register follows every write to its channel
            always_ff @(posedge i_clock) begin
                if (i_rst | do_soft_rst) begin
                    input_reg[ch] <= `DDSC_RESET_CODE;
                end else if (wr_in) begin
                    input_reg[ch] <= frame_code;
                end
            end

            // frame data beats a same-cycle strobe copy: it is newer
            always_ff @(posedge i_clock) begin
                if (i_rst | do_soft_rst) begin
                    dac_reg[ch] <= `DDSC_RESET_CODE;
                end else if (dac_from_frame) begin
                    dac_reg[ch] <= frame_code;
                end else if (dac_from_input) begin
                    dac_reg[ch] <= input_reg[ch];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // mode registers
    // ----------------------------------------------------------------
    // power modes land for both channels in one frame
    always_ff @(posedge i_clock) begin
        if (i_rst | do_soft_rst) begin
            power_mode[0] <= `DDSC_RESET_PMODE;
            power_mode[1] <= `DDSC_RESET_PMODE;
        end else if (do_power) begin
            power_mode[0] <= pmode_a;
            power_mode[1] <= pmode_b;
        end
    end

    // masked channels ignore the hardware load strobe
    always_ff @(posedge i_clock) begin
        if (i_rst | do_soft_rst) begin
            load_mask <= `DDSC_RESET_MASK;
        end else if (do_mask) begin
            load_mask <= frame_mask;
        end
    end

    // reference: data bit 0 high turns it off; only this frame clears it
    always_ff @(posedge i_clock) begin
        if (i_rst | do_soft_rst) begin
            ref_enable <= `DDSC_RESET_REF;
        end else if (do_ref) begin
            ref_enable <= ~frame_flag;
        end
    end

    // chain flag from data bit 0; standalone after any reset
    always_ff @(posedge i_clock) begin
        if (i_rst | do_soft_rst) begin
            chain_enable <= `DDSC_RESET_CHAIN;
        end else if (do_chain) begin
            chain_enable <= frame_flag;
        end
    end

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    // armed by the readback frame, spent by the frame that follows it
    always_ff @(posedge i_clock) begin
        if (i_rst | do_soft_rst) begin
            readback_pending <= 1'b0;
            readback_sel_b <= 1'b0;
        end else if (do_readback) begin
            readback_pending <= 1'b1;
            readback_sel_b <= rb_pick_b;
        end else if (frame_end) begin
            readback_pending <= 1'b0;
        end
    end

    // word held steady for the next frame: code left-aligned in 16 bits
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            readback_word <= '0;
        end else if (readback_pending) begin
            readback_word <= {8'h00,
                (readback_sel_b ? dac_reg[1] : dac_reg[0]),
                6'h00};
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // frame done pulses for every executed frame, reserved ones excluded
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_frame_done <= 1'b0;
            o_gain_two <= 1'b0;
        end else begin
            o_frame_done <= do_any;
            o_gain_two <= gain_level;
        end
    end

    assign o_dac_code_a = dac_reg[0];
    assign o_dac_code_b = dac_reg[1];
    assign o_input_code_a = input_reg[0];
    assign o_input_code_b = input_reg[1];
    assign o_power_mode_a = power_mode[0];
    assign o_power_mode_b = power_mode[1];
    assign o_load_mask = load_mask;
    assign o_ref_enable = ref_enable;
    assign o_chain_enable_flag = chain_enable;

endmodule

// [tb/ddsc_chk.sv]
// Purpose: timing checks on the command port outputs
// Assumes: sees the ports of ddsc_top only, one clock domain
// Notes:   link-side bit order is judged by the bench
module ddsc_chk
    import ddsc_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_frame_select_n,
    input wire logic i_load_dac_n,
    input wire logic i_gain_select,
    input wire logic o_serial_data_out,
    input wire ddsc_code_t o_dac_code_a,
    input wire ddsc_code_t o_dac_code_b,
    input wire ddsc_code_t o_input_code_a,
    input wire ddsc_code_t o_input_code_b,
    input wire ddsc_pmode_t o_power_mode_a,
    input wire logic [1:0] o_load_mask,
    input wire logic o_ref_enable,
    input wire logic o_chain_enable_flag,
    input wire logic o_gain_two,
    input wire logic o_frame_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // strobe outside a frame, nothing masked
    sequence s_strobe;
        $fell(i_load_dac_n) && i_frame_select_n && o_load_mask == 2'h0;
    endsequence
    sequence s_copied;
        o_dac_code_a == o_input_code_a && o_dac_code_b == o_input_code_b;
    endsequence
    property p_strobe; s_strobe |-> ##[3:8] s_copied; endproperty
    property p_done_pulse; o_frame_done |=> !o_frame_done; endproperty
    // execution only well after frame select has risen
    property p_done_late;
        o_frame_done |-> $past(i_frame_select_n, 3) && i_frame_select_n;
    endproperty
    property p_reset_vals;
        $fell(i_rst) |-> o_dac_code_a == 10'h000 && o_input_code_b == 10'h000
            && o_ref_enable && !o_chain_enable_flag && !o_frame_done;
    endproperty
    property p_ref; $fell(o_ref_enable) |-> o_frame_done; endproperty
    property p_chain;
        $changed(o_chain_enable_flag) |-> o_frame_done;
    endproperty
    property p_pmode;
        $changed(o_power_mode_a) || $changed(o_load_mask) |-> o_frame_done;
    endproperty
    // gain pin passes through the synchroniser within eight cycles
    property p_gain;
        (!i_rst && $stable(i_gain_select))[*8] |-> o_gain_two == i_gain_select;
    endproperty
    property p_sdo_idle;
        i_frame_select_n && $past(i_frame_select_n) |-> !o_serial_data_out;
    endproperty
    // a dac b code change needs a frame or a recent strobe
    property p_dac_cause;
        $changed(o_dac_code_b) |-> o_frame_done || !$past(i_load_dac_n, 4);
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("strobe did not copy input codes");
    a_done_pulse: assert property (p_done_pulse)
        else $error("frame done longer than one cycle");
    a_done_late: assert property (p_done_late)
        else $error("frame executed while frame select low");
    a_reset_vals: assert property (p_reset_vals)
        else $error("wrong value after reset");
    a_ref: assert property (p_ref)
        else $error("reference dropped without a frame");
    a_chain: assert property (p_chain)
        else $error("chain flag moved without a frame");
    a_pmode: assert property (p_pmode)
        else $error("mode or mask moved without a frame");
    a_gain: assert property (p_gain)
        else $error("gain output does not follow pin");
    a_sdo_idle: assert property (p_sdo_idle)
        else $error("serial out active between frames");
    a_dac_cause: assert property (p_dac_cause)
        else $error("dac code changed without cause");
endmodule

bind ddsc_top ddsc_chk ddsc_chk_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_frame_select_n(i_frame_select_n), .i_load_dac_n(i_load_dac_n),
    .i_gain_select(i_gain_select), .o_serial_data_out(o_serial_data_out),
    .o_dac_code_a(o_dac_code_a), .o_dac_code_b(o_dac_code_b),
    .o_input_code_a(o_input_code_a), .o_input_code_b(o_input_code_b),
    .o_power_mode_a(o_power_mode_a), .o_load_mask(o_load_mask),
    .o_ref_enable(o_ref_enable), .o_chain_enable_flag(o_chain_enable_flag),
    .o_gain_two(o_gain_two), .o_frame_done(o_frame_done));

// [tb/ddsc_host_model.sv]
// Purpose: host end of the serial link, sends frames and samples sdo
// Assumes: 48 ns serial clock, idle high, stopped between frames
// Notes:   idle data line shows the inverse of the last bit sent
module ddsc_host_model (
    output logic o_sclk,
    output logic o_frame_select_n,
    output logic o_serial_data_in,
    input wire logic i_serial_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // frame driver
    // ----------------------------------------------------------------
    initial begin
        o_sclk = 1'b1;
        o_frame_select_n = 1'b1;
        o_serial_data_in = 1'b0;
    end
    // n bits msb first; sdo taken just before each falling edge
    task automatic xfer(input logic [47:0] bits, input int n,
                        output logic [47:0] got);
        got = '0;
        o_frame_select_n = 1'b0;
        #17;
        for (int i = n - 1; i >= 0; i--) begin
            o_serial_data_in = bits[i];
            #24;
            got[i] = i_serial_data_out;
            o_sclk = 1'b0;
            #24;
            o_sclk = 1'b1;
        end
        #13;
        o_frame_select_n = 1'b1;
        o_serial_data_in = ~o_serial_data_in;
        // long gap so the slow side sees the rise
        #150;
    endtask
endmodule

// [tb/testbench.sv]
// Purpose: self-checking bench of the dual dac serial command port
// Assumes: host model drives the link; bench drives strobe, gain, reset
// Notes:   expectations come from a small model of the command set
module testbench;
    import ddsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, load_dac_n_n = 1'b1, gain = 1'b0;
    wire logic sclk, fs_n, sdi, serial_data_out, done, ref_en, chain, gain2;
    ddsc_code_t dac_a, dac_b, in_a, in_b;
    ddsc_pmode_t pm_a, pm_b;
    logic [1:0] mask;
    logic [9:0] m_in [2], m_dac [2];
    logic [1:0] m_pm [2], m_mk;
    logic m_ref, m_ch, m_rb;
    logic [47:0] got, sh = '0;
    logic [15:0] r = 16'h0023;
    logic [23:0] exp_sdo;
    int failures = 0, num_checks = 0, cycles = 0;

    ddsc_top ddsc_top_inst (.i_clock(clock), .i_rst(rst), .i_sclk(sclk),
        .i_frame_select_n(fs_n), .i_serial_data_in(sdi),
        .i_load_dac_n(load_dac_n_n), .i_gain_select(gain),
        .o_serial_data_out(serial_data_out), .o_dac_code_a(dac_a), .o_dac_code_b(dac_b),
        .o_input_code_a(in_a), .o_input_code_b(in_b),
        .o_power_mode_a(pm_a), .o_power_mode_b(pm_b), .o_load_mask(mask),
        .o_ref_enable(ref_en), .o_chain_enable_flag(chain),
        .o_gain_two(gain2), .o_frame_done(done));
    ddsc_host_model host_inst (.o_sclk(sclk), .o_frame_select_n(fs_n),
        .o_serial_data_in(sdi), .i_serial_data_out(serial_data_out));

    // ----------------------------------------------------------------
    // clock, hang guard, helpers
    // ----------------------------------------------------------------
    always #5 clock = ~clock;
    // run needs about 4900 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [47:0] fw(input logic [3:0] c,
        input logic [3:0] a, input logic [15:0] d);
        return {24'h000000, c, a, d};
    endfunction
    task automatic chk_reg(input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_ser(input logic [23:0] g, input logic [23:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t sdo %h exp %h", $time, g, e);
        end
    endtask
    function automatic void reset_model();
        m_in = '{10'h000, 10'h000};
        m_dac = '{10'h000, 10'h000};
        m_pm = '{2'h0, 2'h0};
        m_mk = 2'h0;
        m_ref = 1'b1;
        m_ch = 1'b0;
        m_rb = 1'b0;
    endfunction
    // model of one executed frame word
    function automatic void exec(input logic [23:0] w);
        logic [3:0] cmd;
        logic sel;
        cmd = w[23:20];
        for (int ch = 0; ch < 2; ch++) begin
            sel = ch ? w[19] : w[16];
            if (sel && cmd inside {4'h1, 4'h3}) m_in[ch] = w[15:6];
            if (sel && cmd == 1 && !load_dac_n_n && !m_mk[ch]) m_dac[ch] = w[15:6];
            if (sel && cmd == 4'h2) m_dac[ch] = m_in[ch];
            if (sel && cmd == 4'h3) m_dac[ch] = w[15:6];
        end
        if (cmd == 4'h4) m_pm = '{w[1:0], w[7:6]};
        if (cmd == 4'h5) m_mk = w[1:0];
        if (cmd == 4'h6) reset_model();
        if (cmd == 4'h7) m_ref = !w[0];
        if (cmd == 4'h8) m_ch = w[0];
        if (cmd == 4'h9) m_rb = (w[19:16] == 4'h8);
    endfunction
    task automatic check_all();
        chk_reg(24'(dac_a), 24'(m_dac[0]));
        chk_reg(24'(dac_b), 24'(m_dac[1]));
        chk_reg(24'(in_a), 24'(m_in[0]));
        chk_reg(24'(in_b), 24'(m_in[1]));
        chk_reg(24'(pm_a), 24'(m_pm[0]));
        chk_reg(24'(pm_b), 24'(m_pm[1]));
        chk_reg(24'(mask), 24'(m_mk));
        chk_reg(24'(ref_en), 24'(m_ref));
        chk_reg(24'(chain), 24'(m_ch));
        chk_reg(24'(gain2), 24'(gain));
    endtask
    // whole or partial frame; the shift register keeps older bits
    task automatic frame(input logic [47:0] b, input int n);
        r = lfsr(r);
        @(posedge clock) gain <= r[3];
        host_inst.xfer(b, n, got);
        sh = (sh << n) | b;
        exec(sh[23:0]);
        repeat (12) @(posedge clock);
        check_all();
    endtask
    task automatic set_load_dac_n(input logic v);
        @(posedge clock) load_dac_n_n <= v;
        for (int ch = 0; ch < 2; ch++) begin
            if (!v && !m_mk[ch]) m_dac[ch] = m_in[ch];
        end
        repeat (10) @(posedge clock);
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        reset_model();
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        repeat (8) @(posedge clock);
        check_all();
        // writes to A, B, both; strobe high so dac registers hold
        foreach (m_mk[k]) begin
            r = lfsr(r);
            frame(fw(4'h1, k ? 4'h8 : 4'h1, r), 24);
        end
        frame(fw(4'h1, 4'h9, lfsr(r)), 24);
        frame(fw(4'h2, 4'h1, 16'h0000), 24);
        set_load_dac_n(1'b0);
        set_load_dac_n(1'b1);
        check_all();
        frame(fw(4'h3, 4'h8, lfsr(r)), 24);
        // masked channel A ignores the strobe
        frame(fw(4'h5, 4'h0, 16'h0001), 24);
        frame(fw(4'h1, 4'h9, ~r), 24);
        set_load_dac_n(1'b0);
        set_load_dac_n(1'b1);
        check_all();
        frame(fw(4'h5, 4'h0, 16'h0000), 24);
        // strobe held low: writes go straight through
        set_load_dac_n(1'b0);
        frame(fw(4'h1, 4'h9, r ^ 16'h5A5A), 24);
        set_load_dac_n(1'b1);
        for (int k = 0; k < 4; k++) begin
            frame(fw(4'h4, 4'h0, {8'h00, 2'(k), 4'hF, 2'(3-k)}), 24);
        end
        frame(fw(4'h7, 4'h0, 16'h0001), 24);
        frame(fw(4'h7, 4'h0, 16'h0000), 24);
        for (int c = 10; c < 16; c++) begin
            frame(fw(4'(c), 4'h9, ~r), 24);
        end
        frame(fw(4'h0, 4'h9, r), 24);
        // short frame borrows its command from the previous one
        frame(48'h000000000031, 24);
        frame({32'h00000000, lfsr(r)}, 16);
        foreach (m_mk[k]) begin
            frame(fw(4'h9, k ? 4'h8 : 4'h1, 16'hFFFF), 24);
            exp_sdo = {8'h00, m_dac[m_rb], 6'h00};
            frame(fw(4'h0, 4'h0, 16'h0000), 24);
            chk_ser(got[23:0], exp_sdo);
        end
        frame(fw(4'h8, 4'h0, 16'h0001), 24);
        r = lfsr(r);
        frame({r, r[7:0], 24'h000000}, 48);
        chk_ser(got[23:0], sh[47:24]);
        frame(fw(4'h8, 4'h0, 16'h0000), 24);
        frame(fw(4'h6, 4'h0, 16'h0000), 24);
        complete_run();
    end
endmodule
